// file: core/accumulator_loadstore_path.sv
// Accumulators, program counter and load/store path with address decode.
// Assumes synchronous pipeline strobes and one outstanding load at a time.
//
// Function
// - Two independent accumulators hold 56 bits each for DSP work.
// - Reads give a 64-bit view, top byte copies the stored sign bit.
// - Writes to the top byte of the view change nothing.
// - The product instruction overwrites the selected accumulator.
// - High write loads view bits 63..32, low write loads bits 31..0.
// - Reads return the high, low or middle 32 bits of the view.
// - Accumulators have no reset value.
// - The program counter is always even.
// - Reset clears the program counter to zero.
// - An input pin chooses big or little endian data order.
// - Signed and unsigned bytes, halfwords and words are handled.
// - Byte and halfword loads sign- or zero-extend to 32 bits.
// - Stores write the whole word, low halfword or low byte.
// - Misaligned halfword or word accesses raise an address exception.
// - 512 MB splits into eight 64 MB blocks, one select each.
// - Block zero holds 2 MB internal and 62 MB external space.
// - Internal accesses drive no external strobes or selects.
// - On-chip RAM is decoded from its base to its top address.
// - The peripheral window splits into 4 KB slots, one per module.
`timescale 1ns/1ps
`default_nettype none
module accumulator_loadstore_path (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire alp_pkg::acc_op_e acc_op,
  input wire logic acc_sel,
  input wire logic [31:0] acc_wdata,
  input wire logic [31:0] mul_lhs,
  input wire logic [31:0] mul_rhs,
  output logic [31:0] acc_rdata,
  output logic acc_rvalid,
  input wire logic pc_load,
  input wire logic [31:0] pc_target,
  input wire logic pc_advance,
  input wire logic pc_advance_word,
  output logic [31:0] instruction_address_counter,
  input wire logic endian_select_pin,
  input wire logic ls_req,
  input wire logic ls_write,
  input wire alp_pkg::size_e ls_size,
  input wire logic ls_signed,
  input wire logic [31:0] ls_addr,
  input wire logic [31:0] ls_wdata,
  output logic ls_busy,
  output logic addr_exc,
  output logic [31:0] ld_data,
  output logic ld_valid,
  input wire logic rd_valid,
  input wire logic [31:0] rd_data,
  output logic [31:0] bus_addr,
  output logic bus_we,
  output logic [3:0] bus_be,
  output logic [31:0] bus_wdata,
  output logic ext_strobe,
  output logic [7:0] memory_block_selects_n,
  output logic ram_strobe,
  output logic sfr_strobe,
  output logic [alp_pkg::SLOT_BITS-1:0] sfr_slot
);
  import alp_pkg::*;

  logic [ACC_BITS-1:0] acc [ACC_COUNT];
  logic signed [63:0] product;
  ls_state_e state;
  logic go;
  logic issue;
  logic targeted;
  logic [1:0] lane;
  logic half_up;
  logic [3:0] next_be;
  logic [31:0] next_wdata;
  size_e pend_size;
  logic pend_signed;
  logic [1:0] pend_lane;
  logic pend_half_up;
  logic [7:0] rd_byte;
  logic [15:0] rd_half;
  logic [31:0] next_ld;
  logic [VIEW_BITS-1:0] sel_view;

  decode_if dif ();

  phys_addr_decoder u_decode (
    .dif(dif)
  );

  function automatic logic [VIEW_BITS-1:0] view(
    input logic [ACC_BITS-1:0] a
  );
    return {{ACC_FILL{a[ACC_SIGN]}}, a};
  endfunction : view

  // Signed 32x32 product for the product instruction
  assign product = $signed(mul_lhs) * $signed(mul_rhs);
  assign sel_view = view(acc[acc_sel]);

  // One storage process per accumulator, deliberately unreset
  for (genvar g = 0; g < ACC_COUNT; g++) begin : g_acc
    always_ff @(posedge ref_clk) begin
      if (acc_sel == 1'(g)) begin
        case (acc_op)
          ACC_HIGH_WRITE: begin
            // Top byte of the word is dropped
            acc[g][ACC_BITS-1:ACC_HI_LSB] <= acc_wdata[HI_KEEP-1:0];
          end
          ACC_LOW_WRITE: begin
            acc[g][ACC_HI_LSB-1:0] <= acc_wdata;
          end
          ACC_PRODUCT: begin
            acc[g] <= product[ACC_BITS-1:0];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Accumulator read port, one cycle latency
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      acc_rdata <= '0;
      acc_rvalid <= 1'b0;
    end else begin
      acc_rvalid <= 1'b0;
      case (acc_op)
        ACC_HIGH_READ: begin
          acc_rdata <= sel_view[VIEW_BITS-1:ACC_HI_LSB];
          acc_rvalid <= 1'b1;
        end
        ACC_LOW_READ: begin
          acc_rdata <= sel_view[ACC_HI_LSB-1:0];
          acc_rvalid <= 1'b1;
        end
        ACC_MIDDLE_READ: begin
          acc_rdata <= sel_view[ACC_MID_LSB +: WORD_BITS];
          acc_rvalid <= 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  // Program counter; bit zero is never loaded
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      instruction_address_counter <= PC_RESET;
    end else if (pc_load) begin
      instruction_address_counter <= {pc_target[31:1], 1'b0};
    end else if (pc_advance) begin
      instruction_address_counter <= instruction_address_counter +
        (pc_advance_word ? PC_STEP_WORD : PC_STEP_HALF);
    end
  end

  assign dif.addr = ls_addr;
  assign dif.size = ls_size;
  assign go = ls_req && (state == LS_IDLE);
  assign issue = go && !dif.misaligned;
  assign targeted = !dif.internal || dif.ram_hit || dif.sfr_hit;

  // Byte lanes follow the endian pin; lane 0 is bits 7..0
  always_comb begin
    lane = endian_select_pin ? ls_addr[1:0] : ~ls_addr[1:0];
    half_up = endian_select_pin ? ls_addr[1] : ~ls_addr[1];
    case (ls_size)
      SZ_BYTE: begin
        next_be = BE_BYTE << lane;
        next_wdata = {4{ls_wdata[7:0]}};
      end
      SZ_HALF: begin
        next_be = half_up ? BE_HALF_HI : BE_HALF_LO;
        next_wdata = {2{ls_wdata[15:0]}};
      end
      default: begin
        next_be = BE_WORD;
        next_wdata = ls_wdata;
      end
    endcase
  end

  // Bus request outputs, one cycle after an accepted request
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      bus_addr <= '0;
      bus_we <= 1'b0;
      bus_be <= '0;
      bus_wdata <= '0;
      ext_strobe <= 1'b0;
      memory_block_selects_n <= SEL_IDLE_N;
      ram_strobe <= 1'b0;
      sfr_strobe <= 1'b0;
      sfr_slot <= '0;
    end else begin
      ext_strobe <= 1'b0;
      ram_strobe <= 1'b0;
      sfr_strobe <= 1'b0;
      memory_block_selects_n <= SEL_IDLE_N;
      if (issue) begin
        bus_addr <= ls_addr;
        bus_we <= ls_write;
        bus_be <= next_be;
        bus_wdata <= next_wdata;
        ram_strobe <= dif.ram_hit;
        sfr_strobe <= dif.sfr_hit;
        sfr_slot <= dif.slot;
        if (!dif.internal) begin
          ext_strobe <= 1'b1;
          memory_block_selects_n <= ~(SEL_ONE << dif.block);
        end
      end
    end
  end

  // Address exception pulse
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      addr_exc <= 1'b0;
    end else begin
      addr_exc <= go && dif.misaligned;
    end
  end

  // Load sequencing: wait for read data from the selected target
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state <= LS_IDLE;
      ls_busy <= 1'b0;
    end else begin
      case (state)
        LS_IDLE: begin
          if (issue && !ls_write && targeted) begin
            state <= LS_WAIT;
            ls_busy <= 1'b1;
          end
        end
        LS_WAIT: begin
          if (rd_valid) begin
            state <= LS_IDLE;
            ls_busy <= 1'b0;
          end
        end
        default: begin
          state <= LS_IDLE;
          ls_busy <= 1'b0;
        end
      endcase
    end
  end

  // Shape of the pending load
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pend_size <= SZ_WORD;
      pend_signed <= 1'b0;
      pend_lane <= '0;
      pend_half_up <= 1'b0;
    end else if (issue && !ls_write) begin
      pend_size <= ls_size;
      pend_signed <= ls_signed;
      pend_lane <= lane;
      pend_half_up <= half_up;
    end
  end

  // Extraction and extension of returned data
  always_comb begin
    rd_byte = rd_data[{pend_lane, 3'b000} +: 8];
    rd_half = pend_half_up ? rd_data[31:16] : rd_data[15:0];
    case (pend_size)
      SZ_BYTE: next_ld = pend_signed ?
        {{24{rd_byte[7]}}, rd_byte} : {24'h00_0000, rd_byte};
      SZ_HALF: next_ld = pend_signed ?
        {{16{rd_half[15]}}, rd_half} : {16'h0000, rd_half};
      default: next_ld = rd_data;
    endcase
  end

  // Loads to unused internal space complete at once with zero
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ld_data <= '0;
      ld_valid <= 1'b0;
    end else begin
      ld_valid <= 1'b0;
      if (state == LS_WAIT && rd_valid) begin
        ld_data <= next_ld;
        ld_valid <= 1'b1;
      end else if (issue && !ls_write && !targeted) begin
        ld_data <= '0;
        ld_valid <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_high_write0;
    acc_op == ACC_HIGH_WRITE && acc_sel == 1'b0;
  endsequence

  sequence s_high_read0;
    acc_op == ACC_HIGH_READ && acc_sel == 1'b0;
  endsequence

  sequence s_bad_access;
    go && dif.misaligned;
  endsequence

  a_pc_always_even: assert property (
    (pc_load || pc_advance) |=> instruction_address_counter[0] == 1'b0)
    else $error("program counter became odd");

  a_pc_reset_zero: assert property (
    $rose(rst_n) |-> instruction_address_counter == PC_RESET)
    else $error("program counter not zero after reset");

  a_read_sign_fill: assert property (
    (acc_op == ACC_HIGH_READ) |=>
      acc_rvalid && acc_rdata[31:24] == {8{acc_rdata[23]}})
    else $error("accumulator top byte not sign filled");

  a_high_write_trim: assert property (
    s_high_write0 ##1 s_high_read0 |=>
      acc_rdata == {{8{$past(acc_wdata[23], 2)}},
                    $past(acc_wdata[23:0], 2)})
    else $error("high write did not land in view bits 63..32");

  a_misalign_no_bus: assert property (
    s_bad_access |=> addr_exc && !ext_strobe && !ram_strobe &&
      !sfr_strobe && !ls_busy)
    else $error("misaligned access reached the bus");

  a_exc_needs_cause: assert property (
    addr_exc |-> $past(go) && $past(ls_size) != SZ_BYTE)
    else $error("address exception without misaligned cause");

  a_select_onehot: assert property (
    ext_strobe |-> $onehot(~memory_block_selects_n))
    else $error("block selects not one-hot");

  a_internal_quiet: assert property (
    (ram_strobe || sfr_strobe) |->
      !ext_strobe && memory_block_selects_n == SEL_IDLE_N)
    else $error("internal access drove external signals");

  a_unsigned_zero: assert property (
    ld_valid && !pend_signed && pend_size == SZ_BYTE |->
      ld_data[31:8] == 24'h00_0000)
    else $error("unsigned byte load not zero extended");

  a_ram_window: assert property (
    issue && (ls_addr & PHYS_MASK) == RAM_BASE |=> ram_strobe)
    else $error("internal RAM base not selected");
endmodule : accumulator_loadstore_path
`default_nettype wire

// file: core/phys_addr_decoder.sv
// Combinational physical address and alignment decoder.
// Assumes the requester holds addr and size stable for the cycle.
`timescale 1ns/1ps
`default_nettype none
module phys_addr_decoder (
  decode_if.decoder dif
);
  import alp_pkg::*;
  logic [31:0] phys;

  always_comb begin
    phys = dif.addr & PHYS_MASK;
    // Eight 64 MB blocks
    dif.block = phys[BLOCK_LSB +: BLOCK_BITS];
    // Top 2 MB of the first 16 MB of block zero stays on chip
    dif.internal = (phys >= INT_BASE) && (phys <= INT_TOP);
    dif.ram_hit = (phys >= RAM_BASE) && (phys <= RAM_TOP);
    dif.sfr_hit = (phys >= SFR_BASE) && (phys <= SFR_TOP);
    dif.slot = phys[SLOT_LSB +: SLOT_BITS];
    case (dif.size)
      SZ_BYTE: dif.misaligned = 1'b0;
      SZ_HALF: dif.misaligned = dif.addr[0];
      default: dif.misaligned = |dif.addr[1:0];
    endcase
  end
endmodule : phys_addr_decoder
`default_nettype wire

// file: shared/alp_pkg.sv
// Constants, types and address map of the accumulator and load/store path.
// Assumes a single 10 MHz processor clock; addresses are byte addresses.
package alp_pkg;
  localparam int ACC_COUNT = 2;
  localparam int ACC_BITS = 56;
  localparam int VIEW_BITS = 64;
  localparam int WORD_BITS = 32;
  localparam int ACC_SIGN = 55;
  localparam int ACC_FILL = 8;
  localparam int ACC_HI_LSB = 32;
  localparam int ACC_MID_LSB = 16;
  localparam int HI_KEEP = 24;
  localparam logic [31:0] PC_RESET = 32'h0000_0000;
  localparam logic [31:0] PC_STEP_HALF = 32'h0000_0002;
  localparam logic [31:0] PC_STEP_WORD = 32'h0000_0004;
  localparam logic [31:0] PHYS_MASK = 32'h1fff_ffff;
  localparam int BLOCK_LSB = 26;
  localparam int BLOCK_BITS = 3;
  localparam int BLOCK_COUNT = 8;
  localparam logic [7:0] SEL_IDLE_N = 8'hff;
  localparam logic [7:0] SEL_ONE = 8'h01;
  localparam logic [31:0] INT_BASE = 32'h00e0_0000;
  localparam logic [31:0] INT_TOP = 32'h00ff_ffff;
  localparam logic [31:0] RAM_BASE = 32'h00f0_0000;
  localparam logic [31:0] RAM_TOP = 32'h00f0_ffff;
  localparam logic [31:0] SFR_BASE = 32'h00e0_0000;
  localparam logic [31:0] SFR_TOP = 32'h00ef_ffff;
  localparam int SLOT_LSB = 12;
  localparam int SLOT_BITS = 8;
  localparam logic [3:0] BE_BYTE = 4'h1;
  localparam logic [3:0] BE_HALF_LO = 4'h3;
  localparam logic [3:0] BE_HALF_HI = 4'hc;
  localparam logic [3:0] BE_WORD = 4'hf;

  typedef enum logic [2:0] {
    ACC_IDLE = 3'h0,
    ACC_HIGH_WRITE = 3'h1,
    ACC_LOW_WRITE = 3'h2,
    ACC_HIGH_READ = 3'h3,
    ACC_LOW_READ = 3'h4,
    ACC_MIDDLE_READ = 3'h5,
    ACC_PRODUCT = 3'h6
  } acc_op_e;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_HALF = 2'h1,
    SZ_WORD = 2'h2
  } size_e;

  typedef enum logic {
    LS_IDLE = 1'b0,
    LS_WAIT = 1'b1
  } ls_state_e;
endpackage : alp_pkg

// file: shared/decode_if.sv
// Carries one access address and size to the physical decoder and back.
// Assumes alp_pkg is compiled first.
`timescale 1ns/1ps
`default_nettype none
interface decode_if;
  import alp_pkg::*;
  logic [31:0] addr;
  size_e size;
  logic [BLOCK_BITS-1:0] block;
  logic internal;
  logic ram_hit;
  logic sfr_hit;
  logic [SLOT_BITS-1:0] slot;
  logic misaligned;
  modport requester (output addr, size,
    input block, internal, ram_hit, sfr_hit, slot, misaligned);
  modport decoder (input addr, size,
    output block, internal, ram_hit, sfr_hit, slot, misaligned);
endinterface : decode_if
`default_nettype wire

// file: tb/accumulator_loadstore_path_tb_top.sv
// Self-checking bench for the accumulator and load/store path.
// Assumes the partner model answers reads on the far side.
`timescale 1ns/1ps
`default_nettype none
module accumulator_loadstore_path_tb_top;
  import alp_pkg::*;
  logic ref_clk, rst_n, acc_sel, acc_rvalid, pc_load, pc_advance;
  logic pc_advance_word, endian_select_pin, ls_req, ls_write, ls_signed;
  logic ls_busy, addr_exc, ld_valid, rd_valid, bus_we;
  logic ext_strobe, ram_strobe, sfr_strobe;
  logic [31:0] acc_wdata, mul_lhs, mul_rhs, acc_rdata, pc_target, pc;
  logic [31:0] ls_addr, ls_wdata, ld_data, rd_data, bus_addr, bus_wdata;
  logic [31:0] fill;
  logic [3:0] bus_be, delay;
  logic [7:0] memory_block_selects_n, sfr_slot;
  acc_op_e acc_op;
  size_e ls_size;
  int fails, checks, cycles;

  accumulator_loadstore_path uut (.ref_clk(ref_clk), .rst_n(rst_n),
    .acc_op(acc_op), .acc_sel(acc_sel), .acc_wdata(acc_wdata),
    .mul_lhs(mul_lhs), .mul_rhs(mul_rhs), .acc_rdata(acc_rdata),
    .acc_rvalid(acc_rvalid), .pc_load(pc_load), .pc_target(pc_target),
    .pc_advance(pc_advance), .pc_advance_word(pc_advance_word),
    .instruction_address_counter(pc),
    .endian_select_pin(endian_select_pin), .ls_req(ls_req),
    .ls_write(ls_write), .ls_size(ls_size), .ls_signed(ls_signed),
    .ls_addr(ls_addr), .ls_wdata(ls_wdata), .ls_busy(ls_busy),
    .addr_exc(addr_exc), .ld_data(ld_data), .ld_valid(ld_valid),
    .rd_valid(rd_valid), .rd_data(rd_data), .bus_addr(bus_addr),
    .bus_we(bus_we), .bus_be(bus_be), .bus_wdata(bus_wdata),
    .ext_strobe(ext_strobe),
    .memory_block_selects_n(memory_block_selects_n),
    .ram_strobe(ram_strobe), .sfr_strobe(sfr_strobe), .sfr_slot(sfr_slot));

  bus_partner_model partner (.ref_clk(ref_clk), .rst_n(rst_n),
    .bus_we(bus_we), .ext_strobe(ext_strobe), .ram_strobe(ram_strobe),
    .sfr_strobe(sfr_strobe), .delay(delay), .fill(fill),
    .rd_valid(rd_valid), .rd_data(rd_data));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic stop_test();
    if (fails == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      stop_test();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // Flags as {ext, ram, sfr, exception, selects}
  task automatic flags(input logic [11:0] exp);
    check({20'h0, ext_strobe, ram_strobe, sfr_strobe, addr_exc,
      memory_block_selects_n}, {20'h0, exp});
  endtask : flags

  task automatic acc(input acc_op_e op, input logic sel,
      input logic [31:0] d);
    @(posedge ref_clk);
    acc_op <= op;
    acc_sel <= sel;
    acc_wdata <= d;
    @(posedge ref_clk);
    acc_op <= ACC_IDLE;
    #1;
  endtask : acc

  task automatic rd(input logic sel, input acc_op_e op,
      input logic [31:0] exp);
    acc(op, sel, 32'h0);
    check(acc_rvalid, 1'b1);
    check(acc_rdata, exp);
  endtask : rd

  task automatic pcop(input logic ld, input logic adv, input logic wd,
      input logic [31:0] t, input logic [31:0] exp);
    @(posedge ref_clk);
    pc_load <= ld;
    pc_advance <= adv;
    pc_advance_word <= wd;
    pc_target <= t;
    @(posedge ref_clk);
    pc_load <= 1'b0;
    pc_advance <= 1'b0;
    #1;
    check(pc, exp);
  endtask : pcop

  task automatic ls(input logic wr, input size_e sz, input logic sg,
      input logic [31:0] a, input logic [31:0] d, input logic [11:0] f);
    @(posedge ref_clk);
    ls_req <= 1'b1;
    ls_write <= wr;
    ls_size <= sz;
    ls_signed <= sg;
    ls_addr <= a;
    ls_wdata <= d;
    @(posedge ref_clk);
    ls_req <= 1'b0;
    #1;
    flags(f);
  endtask : ls

  task automatic ld(input size_e sz, input logic sg, input logic [31:0] a,
      input logic [11:0] f, input logic [31:0] exp);
    int n;
    ls(1'b0, sz, sg, a, 32'h0, f);
    n = 0;
    while (ld_valid !== 1'b1 && n < 20) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check(ld_valid, 1'b1);
    check(ld_data, exp);
  endtask : ld

  task automatic store(input size_e sz, input logic [31:0] a,
      input logic [31:0] d, input logic [11:0] f, input logic [3:0] be,
      input logic [31:0] bd);
    ls(1'b1, sz, 1'b0, a, d, f);
    check({27'h0, bus_we, bus_be}, {28'h1, be});
    check(bus_wdata, bd);
    check(bus_addr, a);
  endtask : store

  task automatic t_acc();
    acc(ACC_HIGH_WRITE, 1'b0, 32'h5a80_1234);
    acc(ACC_LOW_WRITE, 1'b0, 32'h89ab_cdef);
    acc(ACC_HIGH_WRITE, 1'b1, 32'hff7f_0001);
    acc(ACC_LOW_WRITE, 1'b1, 32'h0000_0010);
    rd(1'b0, ACC_HIGH_READ, 32'hff80_1234);
    rd(1'b0, ACC_LOW_READ, 32'h89ab_cdef);
    rd(1'b0, ACC_MIDDLE_READ, 32'h1234_89ab);
    rd(1'b1, ACC_HIGH_READ, 32'h007f_0001);
    rd(1'b1, ACC_MIDDLE_READ, 32'h0001_0000);
    mul_lhs <= 32'hffff_fffd;
    mul_rhs <= 32'h0000_0005;
    acc(ACC_PRODUCT, 1'b1, 32'h0);
    rd(1'b1, ACC_HIGH_READ, 32'hffff_ffff);
    rd(1'b1, ACC_LOW_READ, 32'hffff_fff1);
    rd(1'b0, ACC_LOW_READ, 32'h89ab_cdef);
    // High write followed at once by a high read
    @(posedge ref_clk);
    acc_op <= ACC_HIGH_WRITE;
    acc_sel <= 1'b0;
    acc_wdata <= 32'h3c80_0001;
    @(posedge ref_clk);
    acc_op <= ACC_HIGH_READ;
    @(posedge ref_clk);
    acc_op <= ACC_IDLE;
    #1;
    check(acc_rvalid, 1'b1);
    check(acc_rdata, 32'hff80_0001);
  endtask : t_acc

  task automatic t_pc();
    pcop(1'b1, 1'b0, 1'b0, 32'h0000_1235, 32'h0000_1234);
    pcop(1'b0, 1'b1, 1'b0, 32'h0, 32'h0000_1236);
    pcop(1'b0, 1'b1, 1'b1, 32'h0, 32'h0000_123a);
    pcop(1'b1, 1'b1, 1'b0, 32'hffff_ffff, 32'hffff_fffe);
  endtask : t_pc

  task automatic t_mem();
    int b;
    fill <= 32'h80f1_7f92;
    ld(SZ_BYTE, 1'b1, 32'h00f0_0001, 12'h4ff, 32'hffff_fff1);
    ld(SZ_BYTE, 1'b0, 32'h00f0_0001, 12'h4ff, 32'h0000_00f1);
    ld(SZ_HALF, 1'b1, 32'h00f0_0000, 12'h4ff, 32'hffff_80f1);
    ld(SZ_HALF, 1'b0, 32'h00f0_fffe, 12'h4ff, 32'h0000_7f92);
    delay <= 4'h5;
    ld(SZ_WORD, 1'b1, 32'h0400_0000, 12'h8fd, 32'h80f1_7f92);
    ld(SZ_WORD, 1'b0, 32'h00f1_0000, 12'h0ff, 32'h0);
    endian_select_pin <= 1'b1;
    ld(SZ_BYTE, 1'b1, 32'h00f0_0000, 12'h4ff, 32'hffff_ff92);
    ld(SZ_HALF, 1'b1, 32'h00f0_0002, 12'h4ff, 32'hffff_80f1);
    store(SZ_BYTE, 32'h0000_0101, 32'h1234_56ab, 12'h8fe, 4'h2,
      32'habab_abab);
    endian_select_pin <= 1'b0;
    for (b = 0; b < 8; b++) begin
      store(SZ_WORD, (b == 7) ? 32'hfc00_0000 : ((b << 26) | 32'h100),
        32'h0 + b, {4'h8, ~(8'h1 << b)}, 4'hf, 32'h0 + b);
    end
    store(SZ_BYTE, 32'h0000_0101, 32'h1234_56ab, 12'h8fe, 4'h4,
      32'habab_abab);
    store(SZ_HALF, 32'h00df_fffe, 32'h1234_abcd, 12'h8fe, 4'h3,
      32'habcd_abcd);
    store(SZ_WORD, 32'h00ef_5004, 32'h0, 12'h2ff, 4'hf, 32'h0);
    check(sfr_slot, 32'h0000_00f5);
    store(SZ_WORD, 32'h00f0_fffc, 32'h7, 12'h4ff, 4'hf, 32'h7);
  endtask : t_mem

  task automatic t_align();
    ls(1'b1, SZ_HALF, 1'b0, 32'h0000_0201, 32'h1, 12'h1ff);
    ls(1'b1, SZ_WORD, 1'b0, 32'h0000_0202, 32'h1, 12'h1ff);
    ls(1'b0, SZ_WORD, 1'b0, 32'h00f0_0003, 32'h0, 12'h1ff);
    repeat (6) @(posedge ref_clk);
    #1;
    check({ld_valid, ls_busy}, 32'h0);
    ls(1'b1, SZ_BYTE, 1'b0, 32'h0000_0203, 32'h1, 12'h8fe);
  endtask : t_align

  initial begin
    {rst_n, acc_sel, pc_load, pc_advance, pc_advance_word} = 5'h0;
    {endian_select_pin, ls_req, ls_write, ls_signed} = 4'h0;
    {acc_wdata, mul_lhs, mul_rhs, pc_target, ls_addr, ls_wdata} = '0;
    acc_op = ACC_IDLE;
    ls_size = SZ_BYTE;
    fill = 32'h0;
    delay = 4'h1;
    fails = 0;
    checks = 0;
    cycles = 0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1;
    check(pc, PC_RESET);
    flags(12'h0ff);
    t_acc();
    t_pc();
    t_mem();
    t_align();
    stop_test();
  end
endmodule : accumulator_loadstore_path_tb_top
`default_nettype wire

// file: tb/bus_partner_model.sv
// Behavioural responder standing in for external memory, RAM and peripherals.
// Assumes registered one-cycle strobes from the path under test.
`timescale 1ns/1ps
`default_nettype none
module bus_partner_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic bus_we,
  input wire logic ext_strobe,
  input wire logic ram_strobe,
  input wire logic sfr_strobe,
  input wire logic [3:0] delay,
  input wire logic [31:0] fill,
  output logic rd_valid,
  output logic [31:0] rd_data
);
  logic [3:0] wait_cnt;
  logic take;
  assign take = (ext_strobe | ram_strobe | sfr_strobe) & ~bus_we;
  // Released data lines show the inverse, never the old answer
  assign rd_data = rd_valid ? fill : ~fill;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wait_cnt <= 4'h0;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= 1'b0;
      if (take) begin
        wait_cnt <= delay;
      end else if (wait_cnt != 4'h0) begin
        wait_cnt <= wait_cnt - 4'h1;
        rd_valid <= (wait_cnt == 4'h1);
      end
    end
  end
endmodule : bus_partner_model
`default_nettype wire
